// ===== hdl/idrm_pkg.sv
// idrm_pkg: constants for the dma request and mask block.
// assumes an apb slave with 32-bit data and one word per register.
package idrm_pkg;
    // ==================================================
    // register indices (byte address is four times these)
    localparam logic [7:0] IDX_DMA1_STATUS = 8'h08;
    localparam logic [7:0] IDX_DMA1_SOFT_REQUEST = 8'h09;
    localparam logic [7:0] IDX_DMA1_SINGLE_MASK = 8'h0A;
    localparam logic [7:0] IDX_DMA1_MASTER_CLEAR = 8'h0D;
    localparam logic [7:0] IDX_DMA1_ALL_MASK = 8'h0F;
    localparam logic [7:0] IDX_DMA2_STATUS = 8'h10;
    localparam logic [7:0] IDX_DMA2_SOFT_REQUEST = 8'h12;
    localparam logic [7:0] IDX_DMA2_SINGLE_MASK = 8'h14;
    localparam logic [7:0] IDX_DMA2_ALL_MASK = 8'h1E;
    localparam logic [7:0] IDX_DMA2_MASTER_CLEAR = 8'h1F;
    localparam int ADDR_W = 8;
    localparam int WORD_SHIFT = 2;
    // ==================================================
    // field positions
    localparam int SEL_LSB = 0;
    localparam int SEL_MSB = 1;
    localparam int ACT_BIT = 2;
    localparam int ALL_MSB = 3;
    localparam int STAT_REQ_LSB = 4;
    localparam int CASCADE_CH = 4;
    // ==================================================
    // reset values, cascade select code and synchroniser depth
    localparam logic [7:0] MASK_RESET = 8'hFF;
    localparam logic [3:0] ALL_MASK_RESET = 4'hF;
    localparam logic [7:0] SOFT_RESET = 8'h00;
    localparam logic [1:0] SEL_CASCADE = 2'h0;
    localparam int SYNC_STAGES = 2;
endpackage

// ===== hdl/idrm_sync.sv
// idrm_sync: two-flop synchroniser for a bus of level inputs.
// assumes inputs may change at any time relative to pclk.
`timescale 1ns/1ns
`default_nettype none
module idrm_sync #(
    parameter int WIDTH = 7
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    // ==================================================
    // two stages, first stage read only by second
    logic [WIDTH-1:0] meta_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_q <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ===== hdl/idrm_top.sv
// idrm_top: request and mask logic of two cascaded isa dma controllers.
// assumes an apb master on pclk and asynchronous dreq pins.
// Overview of operation
// - low two bits of a request write pick the controller channel.
// - request write with bit 2 set raises a software request.
// - request write with bit 2 clear drops the software request.
// - software request acts like an asserted dreq, except that its own channel mask does not block it.
// - software requests ignore their own channel mask but still enter priority.
// - second controller request write raises only channels 5 to 7.
// - single mask write with bit 2 set masks the channel.
// - single mask write with bit 2 clear unmasks the channel.
// - reset leaves every channel masked.
// - first all-mask write loads masks 0-3, one disables.
// - second single mask covers channels 4-7, 00 is channel 4.
// - second all-mask bits 0-3 map to channels 4-7.
// - masking channel 4 blocks channels 0-3 through the cascade.
// - all-mask reads return the live mask state.
// - master clear drops requests and sets all masks of a controller.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module idrm_top
    import idrm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [idrm_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] dreq_dma1,
    input wire logic [2:0] dreq_dma2,
    output logic [7:0] chan_req,
    output logic grant_valid,
    output logic [2:0] grant_chan
);
    import idrm_pkg::*;

    // ==================================================
    // dreq synchronisers
    logic [6:0] dreq_s;
    idrm_sync #(.WIDTH(7)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({dreq_dma2, dreq_dma1}),
        .sync_out(dreq_s)
    );
    wire logic [7:0] hw_req = {dreq_s[6:4], 1'b0, dreq_s[3:0]};

    // ==================================================
    // apb decode
    logic [7:0] mask_q;
    logic [7:0] mask_d;
    logic [7:0] soft_q;
    logic [7:0] soft_d;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    wire logic [7:0] idx = {{WORD_SHIFT{1'b0}}, paddr[ADDR_W-1:WORD_SHIFT]};
    wire logic aligned = (paddr[WORD_SHIFT-1:0] == 2'h0);
    wire logic hit_st1 = aligned && (idx == IDX_DMA1_STATUS);
    wire logic hit_rq1 = aligned && (idx == IDX_DMA1_SOFT_REQUEST);
    wire logic hit_sm1 = aligned && (idx == IDX_DMA1_SINGLE_MASK);
    wire logic hit_mc1 = aligned && (idx == IDX_DMA1_MASTER_CLEAR);
    wire logic hit_am1 = aligned && (idx == IDX_DMA1_ALL_MASK);
    wire logic hit_st2 = aligned && (idx == IDX_DMA2_STATUS);
    wire logic hit_rq2 = aligned && (idx == IDX_DMA2_SOFT_REQUEST);
    wire logic hit_sm2 = aligned && (idx == IDX_DMA2_SINGLE_MASK);
    wire logic hit_am2 = aligned && (idx == IDX_DMA2_ALL_MASK);
    wire logic hit_mc2 = aligned && (idx == IDX_DMA2_MASTER_CLEAR);
    wire logic hit_any = hit_st1 || hit_rq1 || hit_sm1 || hit_mc1 || hit_am1
        || hit_st2 || hit_rq2 || hit_sm2 || hit_am2 || hit_mc2;
    // one wait state: pready rises in the second access cycle
    wire logic acc = psel && penable;
    wire logic done = acc && pready_q;
    wire logic wr = done && pwrite && hit_any;
    wire logic [1:0] sel = pwdata[SEL_MSB:SEL_LSB];
    wire logic act = pwdata[ACT_BIT];
    wire logic [2:0] ch1 = {1'b0, sel};
    wire logic [2:0] ch2 = {1'b1, sel};
    wire logic wr_rq1 = wr && hit_rq1;
    wire logic wr_rq2 = wr && hit_rq2 && (sel != SEL_CASCADE);
    wire logic wr_sm1 = wr && hit_sm1;
    wire logic wr_sm2 = wr && hit_sm2;
    wire logic wr_am1 = wr && hit_am1;
    wire logic wr_am2 = wr && hit_am2;
    wire logic wr_mc1 = wr && hit_mc1;
    wire logic wr_mc2 = wr && hit_mc2;

    // ==================================================
    // mask and software request next state
    always_comb
    begin
        mask_d = mask_q;
        soft_d = soft_q;
        if (wr_rq1)
            soft_d[ch1] = act;
        if (wr_rq2)
            soft_d[ch2] = act;
        if (wr_sm1)
            mask_d[ch1] = act;
        if (wr_sm2)
            mask_d[ch2] = act;
        if (wr_am1)
            mask_d[3:0] = pwdata[ALL_MSB:0];
        if (wr_am2)
            mask_d[7:4] = pwdata[ALL_MSB:0];
        if (wr_mc1)
        begin
            mask_d[3:0] = ALL_MASK_RESET;
            soft_d[3:0] = SOFT_RESET[3:0];
        end
        if (wr_mc2)
        begin
            mask_d[7:4] = ALL_MASK_RESET;
            soft_d[7:4] = SOFT_RESET[7:4];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mask_q <= MASK_RESET;
            soft_q <= SOFT_RESET;
        end
        else
        begin
            mask_q <= mask_d;
            soft_q <= soft_d;
        end
    end

    // ==================================================
    // per-channel request to priority logic
    logic [7:0] eff;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_req
            if (gi == CASCADE_CH)
            begin : g_cas
                // cascade carries controller 1, blocked by mask 4
                assign eff[gi] = (|eff[3:0]) && !mask_q[gi];
            end
            else
            begin : g_ch
                assign eff[gi] = (hw_req[gi] && !mask_q[gi]) || soft_q[gi];
            end
        end
    endgenerate
    wire logic [7:0] req_out = {eff[7:4], eff[3:0] & {4{eff[CASCADE_CH]}}};

    // fixed priority: lowest channel first, channel 4 pulls in controller 1 ahead of channels 5 to 7
    logic [2:0] win;
    logic win_v;
    always_comb
    begin
        win = 3'h0;
        win_v = 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            if (req_out[i] && (i != CASCADE_CH))
            begin
                win = 3'(i);
                win_v = 1'b1;
            end
        end
        if (req_out[CASCADE_CH])
        begin
            for (int j = 3; j >= 0; j--)
            begin
                if (req_out[j])
                    win = 3'(j);
            end
        end
        else
        begin
            for (int k = 7; k >= 5; k--)
            begin
                if (req_out[k])
                    win = 3'(k);
            end
        end
    end

    logic [7:0] chan_req_q;
    logic grant_valid_q;
    logic [2:0] grant_chan_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            chan_req_q <= 8'h00;
            grant_valid_q <= 1'b0;
            grant_chan_q <= 3'h0;
        end
        else
        begin
            chan_req_q <= req_out;
            grant_valid_q <= win_v;
            grant_chan_q <= win;
        end
    end

    // ==================================================
    // read data and apb answer
    wire logic [31:0] rd_st1 = {24'h0, hw_req[3:0], 4'h0};
    wire logic [31:0] rd_st2 = {24'h0, hw_req[7:5], 5'h00};
    wire logic [31:0] rd_am1 = {28'h0, mask_q[3:0]};
    wire logic [31:0] rd_am2 = {28'h0, mask_q[7:4]};
    wire logic [31:0] rd_mux = hit_st1 ? rd_st1 : hit_st2 ? rd_st2
        : hit_am1 ? rd_am1 : hit_am2 ? rd_am2 : 32'h0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end
        else
        begin
            pready_q <= acc && !pready_q;
            pslverr_q <= acc && !pready_q && !hit_any;
            if (acc && !pready_q && !pwrite)
                prdata_q <= rd_mux;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign chan_req = chan_req_q;
    assign grant_valid = grant_valid_q;
    assign grant_chan = grant_chan_q;

    // ==================================================
    // checks
    logic rst_seen_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rst_seen_q <= 1'b1;
        else
            rst_seen_q <= 1'b0;
    end

    sequence s_req1_wr(logic a);
        done && pwrite && hit_rq1 && (pwdata[ACT_BIT] == a);
    endsequence

    reset_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
        rst_seen_q |-> mask_q == MASK_RESET)
        else $error("masks not all set after reset");
    soft_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_req1_wr(1'b1) |=> soft_q[$past(pwdata[1:0])])
        else $error("software request not raised");
    soft_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_req1_wr(1'b0) |=> !soft_q[$past(pwdata[1:0])])
        else $error("software request not dropped");
    no_cascade_soft_a: assert property (@(posedge pclk) disable iff (!presetn)
        !soft_q[CASCADE_CH])
        else $error("software request on cascade channel");
    single_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
        done && pwrite && hit_sm2 |=> mask_q[{1'b1, $past(pwdata[1:0])}] == $past(pwdata[2]))
        else $error("single mask write not applied");
    all_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
        done && pwrite && hit_am1 |=> mask_q[3:0] == $past(pwdata[3:0]))
        else $error("all mask write not applied");
    cascade_block_a: assert property (@(posedge pclk) disable iff (!presetn)
        mask_q[CASCADE_CH] && $past(mask_q[CASCADE_CH]) |-> chan_req[3:0] == 4'h0)
        else $error("channels 0-3 pass a masked cascade");
    soft_bypass_a: assert property (@(posedge pclk) disable iff (!presetn)
        soft_q[5] && mask_q[5] |=> chan_req[5])
        else $error("software request blocked by mask");
    master_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
        done && pwrite && hit_mc1 |=> mask_q[3:0] == 4'hF && soft_q[3:0] == 4'h0)
        else $error("master clear incomplete");
    master_clr2_a: assert property (@(posedge pclk) disable iff (!presetn)
        done && pwrite && hit_mc2 |=> mask_q[7:4] == 4'hF && soft_q[7:4] == 4'h0)
        else $error("second master clear incomplete");
    soft_set2_a: assert property (@(posedge pclk) disable iff (!presetn)
        done && pwrite && hit_rq2 && pwdata[1:0] != 2'h0
        |=> soft_q[{1'b1, $past(pwdata[1:0])}] == $past(pwdata[2]))
        else $error("second software request not applied");
    all_mask2_a: assert property (@(posedge pclk) disable iff (!presetn)
        done && pwrite && hit_am2 |=> mask_q[7:4] == $past(pwdata[3:0]))
        else $error("second all mask write not applied");
    grant_valid_a: assert property (@(posedge pclk) disable iff (!presetn)
        grant_valid == (|chan_req))
        else $error("grant valid disagrees with requests");
    read_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
        acc && !pready_q && !pwrite && hit_am2 |=> prdata[3:0] == $past(mask_q[7:4]))
        else $error("all mask read not live state");
endmodule
`default_nettype wire

// ===== tb/idrm_dreq_dev.sv
// idrm_dreq_dev: isa slave devices driving dreq levels.
// assumes the bench sets the wanted levels; pins follow after LAG edges.
`timescale 1ns/1ns
`default_nettype none
module idrm_dreq_dev #(
    parameter int LAG = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [6:0] want,
    output logic [3:0] dreq_dma1,
    output logic [2:0] dreq_dma2
);
    // ==================================================
    // slow device: each pin change lags by LAG edges
    logic [6:0] pipe_q [LAG];
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            for (int i = 0; i < LAG; i++) pipe_q[i] <= 7'h00;
        else
        begin
            pipe_q[0] <= want;
            for (int i = 1; i < LAG; i++) pipe_q[i] <= pipe_q[i-1];
        end
    end
    assign {dreq_dma2, dreq_dma1} = pipe_q[LAG-1];
endmodule
`default_nettype wire

// ===== tb/tb_isa_dma_request_mask_logic.sv
// tb_isa_dma_request_mask_logic: apb tests of the request and mask block.
// assumes idrm_top, idrm_pkg and the dreq device model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_isa_dma_request_mask_logic;
    import idrm_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, grant_valid;
    logic [3:0] dreq_dma1;
    logic [2:0] dreq_dma2, grant_chan;
    logic [7:0] chan_req, mm = 8'hFF, sm = 8'h00;
    logic [6:0] want = 7'h7F;
    int err_total = 0, n_compared = 0, cyc = 0;
    always #5 pclk = ~pclk;
    idrm_top idrm_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dreq_dma1(dreq_dma1), .dreq_dma2(dreq_dma2),
        .chan_req(chan_req), .grant_valid(grant_valid), .grant_chan(grant_chan));
    idrm_dreq_dev idrm_dreq_dev_i (.pclk(pclk), .presetn(presetn), .want(want),
        .dreq_dma1(dreq_dma1), .dreq_dma2(dreq_dma2));
    // ==================================================
    // checking and closing
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            err_total++;
            $display("unexpected %s: expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            wrap_up();
        end
    end
    // ==================================================
    // apb master with reference update on writes
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= {idx[5:0], 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        if (n >= 50) err_total++;
        if (w && err === 1'b0)
            case (idx)
                IDX_DMA1_SOFT_REQUEST: sm[wd[1:0]] = wd[2];
                IDX_DMA2_SOFT_REQUEST: if (wd[1:0] != 2'h0) sm[4+wd[1:0]] = wd[2];
                IDX_DMA1_SINGLE_MASK: mm[wd[1:0]] = wd[2];
                IDX_DMA2_SINGLE_MASK: mm[4+wd[1:0]] = wd[2];
                IDX_DMA1_ALL_MASK: mm[3:0] = wd[3:0];
                IDX_DMA2_ALL_MASK: mm[7:4] = wd[3:0];
                IDX_DMA1_MASTER_CLEAR: begin mm[3:0] = 4'hF; sm[3:0] = 4'h0; end
                IDX_DMA2_MASTER_CLEAR: begin mm[7:4] = 4'hF; sm[7:4] = 4'h0; end
                default: ;
            endcase
        @(posedge pclk);
    endtask
    // expected requests and grant from tracked masks, soft bits and pins
    task automatic req_chk();
        logic [7:0] c;
        logic [2:0] g;
        repeat (8) @(posedge pclk);
        c = ({want[6:4], 1'b0, want[3:0]} & ~mm) | sm;
        c[4] = |c[3:0] & ~mm[4];
        if (mm[4]) c[3:0] = 4'h0;
        g = 3'h0;
        for (int i = 7; i >= 0; i--)
            if (c[i] && i != 4 && (c[4] ? i < 4 : i > 4)) g = 3'(i);
        chk("chan_req", {24'h0, c}, {24'h0, chan_req});
        chk("grant_valid", {31'h0, |c}, {31'h0, grant_valid});
        if (|c) chk("grant_chan", {29'h0, g}, {29'h0, grant_chan});
    endtask
    // ==================================================
    // tests
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, IDX_DMA1_ALL_MASK, 0);
        chk("all_mask1", 32'hF, rd);
        apb(0, IDX_DMA2_ALL_MASK, 0);
        chk("all_mask2", 32'hF, rd);
        req_chk();
        $display("test reset done");
        apb(1, IDX_DMA2_SINGLE_MASK, 32'h0);
        for (int ch = 0; ch < 4; ch++)
        begin
            apb(1, IDX_DMA1_SOFT_REQUEST, 32'(ch) | 32'h4);
            req_chk();
            apb(1, IDX_DMA1_SOFT_REQUEST, 32'(ch));
            req_chk();
        end
        for (int s = 1; s < 4; s++)
        begin
            apb(1, IDX_DMA2_SOFT_REQUEST, 32'(s) | 32'h4);
            req_chk();
            apb(1, IDX_DMA2_SOFT_REQUEST, 32'(s));
            req_chk();
        end
        $display("test soft request done");
        for (int ch = 0; ch < 8; ch++)
        begin
            apb(1, ch < 4 ? IDX_DMA1_SINGLE_MASK : IDX_DMA2_SINGLE_MASK, 32'(ch % 4));
            req_chk();
        end
        for (int ch = 7; ch >= 0; ch--)
        begin
            apb(1, ch < 4 ? IDX_DMA1_SINGLE_MASK : IDX_DMA2_SINGLE_MASK, 32'(ch % 4) | 32'h4);
            req_chk();
        end
        $display("test single mask done");
        want <= 7'h55;
        apb(1, IDX_DMA2_ALL_MASK, 32'h0);
        apb(1, IDX_DMA1_ALL_MASK, 32'h5);
        req_chk();
        apb(0, IDX_DMA1_STATUS, 0);
        chk("status1", 32'h50, rd);
        apb(0, IDX_DMA2_STATUS, 0);
        chk("status2", 32'hA0, rd);
        apb(0, IDX_DMA1_ALL_MASK, 0);
        chk("all_mask1", 32'h5, rd);
        apb(1, IDX_DMA2_ALL_MASK, 32'h1);
        apb(1, IDX_DMA1_SOFT_REQUEST, 32'h6);
        req_chk();
        apb(0, IDX_DMA2_ALL_MASK, 0);
        chk("all_mask2", 32'h1, rd);
        $display("test all mask done");
        apb(1, IDX_DMA2_ALL_MASK, 32'h0);
        apb(1, IDX_DMA1_ALL_MASK, 32'h0);
        apb(1, IDX_DMA1_MASTER_CLEAR, 32'h0);
        req_chk();
        apb(0, IDX_DMA1_ALL_MASK, 0);
        chk("all_mask1", 32'hF, rd);
        apb(1, IDX_DMA2_SOFT_REQUEST, 32'h6);
        apb(1, IDX_DMA2_MASTER_CLEAR, 32'h0);
        req_chk();
        apb(0, IDX_DMA2_ALL_MASK, 0);
        chk("all_mask2", 32'hF, rd);
        apb(0, 8'h01, 0);
        chk("pslverr", 32'h1, {31'h0, err});
        $display("test master clear done");
        apb(1, IDX_DMA2_ALL_MASK, 32'h0);
        apb(1, IDX_DMA1_SOFT_REQUEST, 32'h5);
        presetn <= 0;
        mm = 8'hFF;
        sm = 8'h00;
        repeat (10) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, IDX_DMA2_ALL_MASK, 0);
        chk("all_mask2", 32'hF, rd);
        req_chk();
        $display("test mid-run reset done");
        wrap_up();
    end
endmodule
`default_nettype wire
